/* core/rtc_core.sv */
// Notes on behaviour
// [RL1] year divisible by four is leap
// [RL2] seconds 00..59, carry to minutes
// [RL3] minutes 00..59, carry to hours
// [RL4] hours 00..23, carry date and weekday
// [RL5] weekday counts 00..06 then wraps
// [RL6] date end depends on month, leap
// [RL7] month 1..12, wrap advances year
// [RL8] year 00..99 wraps to 00
// [RL9] alarm field compared only when disable 0
// [RL10] write 0 clears flag, 1 keeps
// [RL11] interrupt low when flag and enable
// [RL12] square enable 0 releases output pin
// [RL13] rate field picks one of four
// [RL14] oscillator failure sets fail flag
// [RL15] halt stops only counting chain
// [RL16] stopped oscillator resets registers, exceptions one
// [RL17] no answer above address 0f
// [RL18] master keeps serial clock under 400k; the testbench master clocks it at 12.5 MHz (10 mclk cycles of 8 ns per bit)
// [RL19] unimplemented bits hold no storage
// [RL20] software loads only logical values
// [RL21] flag set on entering match only
// [RL22] answers slave address a2/a3 only
// [RL23] pointer increments after every data byte
// [RL24] second tick from 32768 oscillator edges
// [RL25] unimplemented bits read zero
`timescale 1ns/100ps
`default_nettype none
module rtc_core
	import rtc_pkg::*;
#(
	parameter int osc_timeout = 64
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// oscillator input and halt control
	input  wire logic osc_clk,
	input  wire logic count_halt,
	// serial bus
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// open-drain outputs
	output logic      irq_n_out,
	output logic      irq_n_oe,
	output logic      square_wave_out,
	output logic      square_wave_oe,
	// status
	output logic      time_halted
);
	logic [2:0]  sync_q;
	logic        osc_s;
	logic        scl_s;
	logic        sda_s;
	logic        osc_d;
	logic        osc_rise;
	logic [7:0]  stall_cnt;
	logic        osc_stopped;
	logic        int_rst;
	logic        halt_s;
	logic [14:0] div;
	logic        tick;
	time_t       t;
	time_t       next_t;
	logic        pending;
	logic        irq_enable;
	logic [3:0]  field_dis;
	logic [6:0]  al_minute;
	logic [5:0]  al_hour;
	logic [5:0]  al_date;
	logic [2:0]  al_weekday;
	logic        sq_enable;
	logic [1:0]  sq_rate;
	logic        osc_fail;
	logic        match;
	logic        match_d;
	logic [7:0]  rdata;
	logic [7:0]  sec_inc;
	logic        slave_sda_oe;
	reg_req_t    req;
	logic        sq_level;
	logic [7:0]  last_day;
	logic        leap;

	rtc_sync #(.width(3)) u_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in ({osc_clk, scl_in, sda_in}),
		.sync_out (sync_q)
	);
	assign osc_s = sync_q[2];
	assign scl_s = sync_q[1];
	assign sda_s = sync_q[0];

	rtc_sync #(.width(1)) u_halt_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in (count_halt),
		.sync_out (halt_s)
	);

	assign osc_rise = osc_s & ~osc_d;

	// oscillator watchdog and internal reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_d       <= 1'b0;
			stall_cnt   <= 8'h00;
			osc_stopped <= 1'b1;
		end else begin
			osc_d <= osc_s;
			if (osc_rise) begin
				stall_cnt   <= 8'h00;
				osc_stopped <= 1'b0;
			end else if (stall_cnt == 8'(osc_timeout)) begin
				osc_stopped <= 1'b1;
			end else begin
				stall_cnt <= stall_cnt + 8'h01;
			end
		end
	end
	assign int_rst = rst | osc_stopped; // RL16

	rtc_i2c_slave u_slave (
		.mclk   (mclk),
		.rst    (int_rst), // RL16
		.scl    (scl_s),
		.sda    (sda_s),
		.sda_oe (slave_sda_oe),
		.req    (req),
		.rdata  (rdata)
	);

	// one-second divider
	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			div  <= 15'h0000;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (osc_rise) begin
				div <= div + 15'h0001;
				if (div == 15'(osc_per_second - 1)) begin
					tick <= 1'b1; // RL24
				end
			end
		end
	end

	assign leap = (t.year[4] == 1'b0) ? (t.year[1:0] == 2'h0)
	                                  : (t.year[1:0] == 2'h2); // RL1
	always_comb begin
		case (t.month)
		8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
		month_feb:                  last_day = leap ? 8'h29 : 8'h28;
		default:                    last_day = 8'h31;
		endcase
	end // RL6

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction
	assign sec_inc = bcd_inc({1'b0, t.seconds[6:0]});

	// counting chain
	always_comb begin
		next_t = t;
		if (t.seconds[6:0] == 7'h59) begin // RL2
			next_t.seconds[6:0] = 7'h00;
			if (t.minutes == 8'h59) begin // RL3
				next_t.minutes = 8'h00;
				if (t.hours == 8'h23) begin // RL4
					next_t.hours   = 8'h00;
					next_t.weekday = (t.weekday == 8'h06) ? 8'h00 : t.weekday + 8'h01; // RL5
					if (t.date == last_day) begin // RL6
						next_t.date = 8'h01;
						if (t.month == 8'h12) begin // RL7
							next_t.month = 8'h01;
							next_t.year  = (t.year == 8'h99) ? 8'h00 : bcd_inc(t.year); // RL8
						end else begin
							next_t.month = bcd_inc(t.month);
						end
					end else begin
						next_t.date = bcd_inc(t.date);
					end
				end else begin
					next_t.hours = bcd_inc(t.hours);
				end
			end else begin
				next_t.minutes = bcd_inc(t.minutes);
			end
		end else begin
			next_t.seconds[6:0] = sec_inc[6:0];
		end
	end

	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			t <= '0;
		end else if (req.wr) begin
			case (req.addr)
			addr_seconds: t.seconds[6:0] <= req.wdata[6:0]; // RL19
			addr_minutes: t.minutes      <= {1'b0, req.wdata[6:0]};
			addr_hours:   t.hours        <= {2'b00, req.wdata[5:0]};
			addr_date:    t.date         <= {2'b00, req.wdata[5:0]};
			addr_weekday: t.weekday      <= {5'h00, req.wdata[2:0]};
			addr_month:   t.month        <= {3'h0, req.wdata[4:0]};
			addr_year:    t.year         <= req.wdata;
			default:      t              <= t;
			endcase
		end else if (tick && !halt_s) begin // RL15
			t <= next_t;
		end
	end

	// oscillator fail flag, held through the internal reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_fail <= 1'b1;
		end else if (osc_stopped) begin
			osc_fail <= 1'b1; // RL14
		end else if (req.wr && req.addr == addr_seconds) begin
			osc_fail <= req.wdata[bit_osc_fail];
		end
	end

	// interrupt enable
	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			irq_enable <= 1'b0;
		end else if (req.wr && req.addr == addr_ctrl_two) begin
			irq_enable <= req.wdata[bit_irq_enable]; // RL11
		end
	end

	// square-wave control
	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			sq_enable <= 1'b1; // RL12
			sq_rate   <= rate_32k;
		end else if (req.wr && req.addr == addr_square) begin
			sq_enable <= req.wdata[bit_sq_enable];
			sq_rate   <= req.wdata[1:0];
		end
	end

	// alarm registers
	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			field_dis  <= 4'hf; // RL16
			al_minute  <= 7'h00;
			al_hour    <= 6'h00;
			al_date    <= 6'h00;
			al_weekday <= 3'h0;
		end else if (req.wr) begin
			case (req.addr)
			addr_al_minute:  {field_dis[0], al_minute}  <= {req.wdata[7], req.wdata[6:0]};
			addr_al_hour:    {field_dis[1], al_hour}    <= {req.wdata[7], req.wdata[5:0]};
			addr_al_date:    {field_dis[2], al_date}    <= {req.wdata[7], req.wdata[5:0]};
			addr_al_weekday: {field_dis[3], al_weekday} <= {req.wdata[7], req.wdata[2:0]};
			default:         field_dis <= field_dis;
			endcase
		end
	end

	// alarm compare
	assign match = (field_dis[0] || t.minutes[6:0] == al_minute) &&
	               (field_dis[1] || t.hours[5:0] == al_hour) &&
	               (field_dis[2] || t.date[5:0] == al_date) &&
	               (field_dis[3] || t.weekday[2:0] == al_weekday); // RL9

	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			match_d <= 1'b1;
			pending <= 1'b0;
		end else begin
			match_d <= match;
			if (match && !match_d) begin
				pending <= 1'b1; // RL21
			end else if (req.wr && req.addr == addr_ctrl_two && !req.wdata[bit_pending]) begin
				pending <= 1'b0; // RL10
			end
		end
	end

	// read mux
	always_ff @(posedge mclk or posedge int_rst) begin
		if (int_rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
			addr_ctrl_two:   rdata <= {4'h0, pending, 1'b0, irq_enable, 1'b0}; // RL25
			addr_seconds:    rdata <= {osc_fail, t.seconds[6:0]};
			addr_minutes:    rdata <= t.minutes;
			addr_hours:      rdata <= t.hours;
			addr_date:       rdata <= t.date;
			addr_weekday:    rdata <= t.weekday;
			addr_month:      rdata <= t.month;
			addr_year:       rdata <= t.year;
			addr_al_minute:  rdata <= {field_dis[0], al_minute};
			addr_al_hour:    rdata <= {field_dis[1], 1'b0, al_hour};
			addr_al_date:    rdata <= {field_dis[2], 1'b0, al_date};
			addr_al_weekday: rdata <= {field_dis[3], 4'h0, al_weekday};
			addr_square:     rdata <= {sq_enable, 5'h00, sq_rate};
			default:         rdata <= 8'h00;
			endcase
		end
	end

	// square-wave source
	always_comb begin
		case (sq_rate) // RL13
		rate_32k: sq_level = osc_s;
		rate_1k:  sq_level = div[4];
		rate_32:  sq_level = div[9];
		default:  sq_level = div[14];
		endcase
	end

	// registered pin drivers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sda_out         <= 1'b0;
			sda_oe          <= 1'b0;
			irq_n_out       <= 1'b0;
			irq_n_oe        <= 1'b0;
			square_wave_out <= 1'b0;
			square_wave_oe  <= 1'b0;
			time_halted     <= 1'b0;
		end else begin
			sda_out         <= 1'b0;
			sda_oe          <= slave_sda_oe;
			irq_n_out       <= 1'b0;
			irq_n_oe        <= pending & irq_enable; // RL11
			square_wave_out <= 1'b0;
			square_wave_oe  <= sq_enable & ~sq_level & ~osc_stopped; // RL12
			time_halted     <= halt_s;
		end
	end
endmodule
`default_nettype wire

/* core/rtc_i2c_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module rtc_i2c_slave
	import rtc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// synchronised bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe,
	// register access
	output var reg_req_t    req,
	input  wire logic [7:0] rdata
);
	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_dev   = 3'b001,
		st_ack   = 3'b011,
		st_data  = 3'b010,
		st_send  = 3'b110,
		st_mack  = 3'b111
	} state_t;

	state_t     state;
	logic       scl_d;
	logic       sda_d;
	logic [3:0] bitcnt;
	logic [7:0] shift;
	logic       reading;
	logic       have_ptr;
	logic [7:0] ptr;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;

	assign scl_rise   = scl & ~scl_d;
	assign scl_fall   = ~scl & scl_d;
	assign start_seen = scl & scl_d & sda_d & ~sda;
	assign stop_seen  = scl & scl_d & ~sda_d & sda;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state    <= st_idle;
			bitcnt   <= 4'h0;
			shift    <= 8'h00;
			reading  <= 1'b0;
			have_ptr <= 1'b0;
			ptr      <= 8'h00;
			sda_oe   <= 1'b0;
			req      <= '0;
		end else begin
			req.wr <= 1'b0;
			req.rd <= 1'b0;
			if (start_seen) begin
				state    <= st_dev;
				bitcnt   <= 4'h0;
				have_ptr <= 1'b0;
				sda_oe   <= 1'b0;
			end else if (stop_seen) begin
				state  <= st_idle;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				st_idle: begin
					sda_oe <= 1'b0;
				end
				st_dev, st_data: begin
					if (scl_rise) begin
						shift  <= {shift[6:0], sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						if (state == st_dev) begin
							if (shift[7:1] == slave_addr) begin // RL22
								reading <= shift[0];
								sda_oe  <= 1'b1;
								state   <= st_ack;
								if (shift[0]) begin
									req.rd   <= 1'b1;
									req.addr <= ptr;
								end
							end else begin
								state <= st_idle;
							end
						end else if (!have_ptr) begin
							ptr      <= shift;
							have_ptr <= 1'b1;
							sda_oe   <= (shift <= addr_last_decode); // RL17
							state    <= st_ack;
						end else begin
							req.wr    <= 1'b1;
							req.addr  <= ptr;
							req.wdata <= shift;
							ptr       <= ptr + 8'h01; // RL23
							sda_oe    <= (ptr <= addr_last_decode); // RL17
							state     <= st_ack;
						end
					end
				end
				st_ack: begin
					if (scl_fall) begin
						if (reading) begin
							shift  <= rdata;
							sda_oe <= ~rdata[7];
							bitcnt <= 4'h1;
							ptr    <= ptr + 8'h01; // RL23
							state  <= st_send;
						end else begin
							sda_oe <= 1'b0;
							state  <= st_data;
						end
					end
				end
				st_send: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							sda_oe <= 1'b0;
							state  <= st_mack;
						end else begin
							sda_oe <= ~shift[3'h7 - bitcnt[2:0]];
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				st_mack: begin
					if (scl_rise) begin
						if (sda) begin
							state <= st_idle;
						end else begin
							req.rd   <= 1'b1;
							req.addr <= ptr;
							state    <= st_ack;
						end
					end
				end
				default: state <= st_idle;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* core/rtc_pkg.sv */
package rtc_pkg;
	localparam logic [7:0] addr_ctrl_one   = 8'h00;
	localparam logic [7:0] addr_ctrl_two   = 8'h01;
	localparam logic [7:0] addr_seconds    = 8'h02;
	localparam logic [7:0] addr_minutes    = 8'h03;
	localparam logic [7:0] addr_hours      = 8'h04;
	localparam logic [7:0] addr_date       = 8'h05;
	localparam logic [7:0] addr_weekday    = 8'h06;
	localparam logic [7:0] addr_month      = 8'h07;
	localparam logic [7:0] addr_year       = 8'h08;
	localparam logic [7:0] addr_al_minute  = 8'h09;
	localparam logic [7:0] addr_al_hour    = 8'h0a;
	localparam logic [7:0] addr_al_date    = 8'h0b;
	localparam logic [7:0] addr_al_weekday = 8'h0c;
	localparam logic [7:0] addr_square     = 8'h0d;
	localparam logic [7:0] addr_last_decode = 8'h0f;
	localparam logic [6:0] slave_addr      = 7'h51;
	localparam int         bit_pending     = 3;
	localparam int         bit_irq_enable  = 1;
	localparam int         bit_field_dis   = 7;
	localparam int         bit_osc_fail    = 7;
	localparam int         bit_sq_enable   = 7;
	localparam logic [1:0] rate_32k        = 2'h0;
	localparam logic [1:0] rate_1k         = 2'h1;
	localparam logic [1:0] rate_32         = 2'h2;
	localparam logic [1:0] rate_1          = 2'h3;
	localparam int         osc_per_second  = 32768;
	localparam logic [7:0] month_feb       = 8'h02;
	localparam logic [7:0] osc_timeout_default = 8'h40;
	localparam logic [7:0] reset_seconds   = 8'h80;
	localparam logic [7:0] reset_alarm     = 8'h80;
	localparam logic [7:0] reset_square    = 8'h80;

	typedef struct packed {
		logic [7:0] seconds;
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] date;
		logic [7:0] weekday;
		logic [7:0] month;
		logic [7:0] year;
	} time_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

/* core/rtc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module rtc_sync
	import rtc_pkg::*;
#(
	parameter int width = 1
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// levels
	input  wire logic [width-1:0] async_in,
	output logic      [width-1:0] sync_out
);
	logic [width-1:0] stage_one;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage_one <= '0;
			sync_out  <= '0;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule
`default_nettype wire

/* tb/i2c_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
	// clock
	input  wire logic mclk,
	// bus lines, sda pulled up
	input  wire logic sda,
	output logic      scl,
	output logic      sda_oe
);
	initial begin
		scl    = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// data moves only while scl is low
	task automatic bitx(input logic o, output logic i);
		scl = 1'b0;
		tk(2);
		sda_oe = !o;
		tk(3);
		scl = 1'b1;
		tk(2);
		i = sda;
		tk(3);
	endtask
	// byte msb first, then the acknowledge slot
	task automatic xb(input logic [7:0] o, input logic ao,
		output logic [7:0] i, output logic ai);
		for (int b = 7; b >= 0; b--)
			bitx(o[b], i[b]);
		bitx(ao, ai);
	endtask
	task automatic start();
		scl = 1'b0;
		tk(2);
		sda_oe = 1'b0;
		tk(3);
		scl = 1'b1;
		tk(5);
		sda_oe = 1'b1;
		tk(5);
	endtask
	task automatic stop();
		scl = 1'b0;
		tk(2);
		sda_oe = 1'b1;
		tk(3);
		scl = 1'b1;
		tk(5);
		sda_oe = 1'b0;
		tk(5);
	endtask
endmodule
`default_nettype wire

/* tb/rtc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rtc_assertions
	import rtc_pkg::*;
#(
	parameter int osc_timeout = 64
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// inputs
	input wire logic osc_clk,
	input wire logic count_halt,
	input wire logic scl_in,
	input wire logic sda_in,
	// outputs
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic square_wave_out,
	input wire logic square_wave_oe,
	input wire logic time_halted
);
	logic       osc_q;
	logic [7:0] osc_age;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// cycles since the oscillator last moved
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_q   <= 1'b0;
			osc_age <= 8'h00;
		end else begin
			osc_q <= osc_clk;
			if (osc_clk != osc_q)
				osc_age <= 8'h00;
			else if (osc_age != 8'hff)
				osc_age <= osc_age + 8'h01;
		end
	end
	irq_drain_a: assert property (irq_n_oe |-> !irq_n_out)
		else $error("interrupt pin driven high");
	sq_drain_a: assert property (square_wave_oe |-> !square_wave_out)
		else $error("square pin driven high");
	halt_on_a: assert property ($rose(count_halt) |-> ##[1:5] time_halted)
		else $error("halt not seen");
	halt_off_a: assert property ($fell(count_halt) |-> ##[1:5] !time_halted)
		else $error("halt not released");
	osc_quiet_a: assert property (osc_age > osc_timeout + 8 |->
		!sda_oe && !irq_n_oe && !square_wave_oe)
		else $error("outputs active with oscillator stopped");
	rst_quiet_a: assert property ($fell(rst) |->
		!sda_oe && !irq_n_oe && !square_wave_oe)
		else $error("outputs active after reset");
	sda_edge_a: assert property (scl_in [*6] |-> $stable(sda_oe))
		else $error("data changed while clock high");
	ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
		else $error("data low too short");
	sq_osc_a: assert property ($changed(square_wave_oe) |-> osc_age < 8)
		else $error("square edge without oscillator edge");
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int osc_timeout = 16;
	logic       mclk;
	logic       rst;
	logic       osc_clk;
	logic       osc_en;
	logic       count_halt;
	logic       scl;
	logic       m_oe;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic       irq_n_out;
	logic       irq_n_oe;
	logic       square_wave_out;
	logic       square_wave_oe;
	logic       time_halted;
	logic       k;
	logic [7:0] j;
	logic [7:0] wbuf [8];
	logic [7:0] rbuf [8];
	int         hp [3] = '{1, 32, 1024};
	int         error_cnt;
	int         n_checks;
	int         cyc;
	int         c;
	assign sda = !(m_oe || sda_oe);
	rtc_core #(.osc_timeout(osc_timeout)) dut (
		.mclk, .rst, .osc_clk, .count_halt, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .irq_n_out, .irq_n_oe, .square_wave_out,
		.square_wave_oe, .time_halted
	);
	i2c_master_model m (.mclk, .sda, .scl, .sda_oe(m_oe));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		osc_clk = 1'b0;
		#1;
		forever #8 osc_clk = osc_en ? ~osc_clk : osc_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] a, input int n);
		m.start();
		m.xb(8'ha2, 1'b1, j, k);
		m.xb(a, 1'b1, j, k);
		for (int i = 0; i < n; i++)
			m.xb(wbuf[i], 1'b1, j, k);
		m.stop();
	endtask
	task automatic rb(input logic [7:0] a, input int n);
		m.start();
		m.xb(8'ha2, 1'b1, j, k);
		m.xb(a, 1'b1, j, k);
		m.start();
		m.xb(8'ha3, 1'b1, j, j[0]);
		for (int i = 0; i < n; i++)
			m.xb(8'hff, i == n - 1, rbuf[i], j[0]);
		m.stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wbuf[0] = d;
		wb(a, 1);
		rb(a, 1);
	endtask
	// cycles until the square output next changes
	task automatic half(output int n);
		logic s;
		s = square_wave_oe;
		n = 0;
		while (square_wave_oe === s && n < 4000) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	task automatic done(input string s);
		$display("%0t: %s done", $time, s);
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			$display("Error at %0t: timeout", $time);
			end_sim();
		end
	end
	initial begin
		rst = 1'b1;
		osc_en = 1'b1;
		count_halt = 1'b0;
		m.tk(20);
		rst = 1'b0;
		m.tk(20);
		for (int a = 0; a < 14; a++) begin
			rb(a[7:0], 1);
			chk(rbuf[0], (a == 2 || a > 8) ? 8'h80 : 8'h00);
		end
		done("reset values");
		rb(8'h10, 1);
		chk({7'h0, k}, 8'h01);
		rb(8'h0f, 1);
		chk({7'h0, k}, 8'h00);
		m.start();
		m.xb(8'hb2, 1'b1, j, k);
		m.stop();
		chk({7'h0, k}, 8'h01);
		count_halt = 1'b1;
		m.tk(6);
		chk({7'h0, time_halted}, 8'h01);
		wr(8'h01, 8'hff);
		chk(rbuf[0], 8'h02);
		chk({7'h0, irq_n_oe}, 8'h00);
		done("decode");
		wbuf = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04, 8'h00};
		wb(8'h02, 7);
		rb(8'h02, 7);
		for (int i = 0; i < 7; i++)
			chk(rbuf[i], wbuf[i]);
		wbuf = '{8'h00, 8'h00, 8'h85, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wb(8'h09, 4);
		for (int r = 0; r < 3; r++) begin
			wr(8'h0d, 8'h80 | r[7:0]);
			half(c);
			half(c);
			chk({7'h0, c >= hp[r] - 2 && c <= hp[r] + 2}, 8'h01);
		end
		wr(8'h0d, 8'h83);
		half(c);
		chk({7'h0, c == 4000}, 8'h01);
		wr(8'h0d, 8'h03);
		half(c);
		chk({7'h0, c == 4000 && !square_wave_oe}, 8'h01);
		done("square wave");
		count_halt = 1'b0;
		m.tk(6);
		chk({7'h0, time_halted}, 8'h00);
		wr(8'h01, 8'h02);
		c = 0;
		do begin
			rb(8'h02, 1);
			c++;
		end while (rbuf[0] === 8'h59 && c < 400);
		rb(8'h02, 7);
		wbuf = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04, 8'h00};
		for (int i = 0; i < 7; i++)
			chk(rbuf[i], wbuf[i]);
		chk({7'h0, irq_n_oe}, 8'h01);
		wr(8'h01, 8'h0a);
		chk(rbuf[0], 8'h0a);
		wr(8'h01, 8'h02);
		chk(rbuf[0], 8'h02);
		chk({7'h0, irq_n_oe}, 8'h00);
		done("calendar and alarm");
		osc_en = 1'b0;
		m.tk(osc_timeout + 30);
		osc_en = 1'b1;
		m.tk(30);
		rb(8'h02, 1);
		chk(rbuf[0], 8'h80);
		rb(8'h01, 1);
		chk(rbuf[0], 8'h00);
		done("oscillator stop");
		end_sim();
	end
endmodule
bind rtc_core rtc_assertions #(.osc_timeout(osc_timeout)) u_chk (
	.mclk, .rst, .osc_clk, .count_halt, .scl_in, .sda_in, .sda_out, .sda_oe,
	.irq_n_out, .irq_n_oe, .square_wave_out, .square_wave_oe, .time_halted
);
`default_nettype wire
